/* logic/pbi_pkg.sv */
// Purpose: constants and types for the parallel bus pin interface
// Assumes: one bus clock, all pins sampled and driven on its rising edge
// Notes:   Function list follows
// Function
// R1: sample and drive pins on rising edge
// R2: works from static clock up to 33 MHz
// R3: reset floats all outputs, clears state; req_b is driven high in reset instead
// R4: frame start carries address and command
// R5: frame held, dropped for last data phase
// R6: initiator ready means write data valid
// R7: target ready means read data valid
// R8: transfer only when both readies low
// R9: target stop ends the master's transaction
// R10: locked target refuses other masters
// R11: master never drives or takes lock
// R12: configuration access only with idsel
// R13: claim with devsel after decoding own access
// R14: master samples devsel for a claim
// R15: own request line when wanting bus
// R16: master starts only when granted
// R17: parity error reported two clocks later
// R18: parity error driven high one clock, released
// R19: system error for address parity, fatal
// R20: interrupt is level, active low, open drain
// R21: interrupt only on first interrupt line
// R22: parity covers data and enables, one clock later
package pbi_pkg;
    localparam int         DATA_W     = 32;
    localparam int         CBE_W      = 4;
    localparam int         FIFO_DEPTH = 32;
    localparam int         FIFO_AW    = 5;
    localparam int         DEC_LO     = 12;
    localparam int         DEC_W      = DATA_W - DEC_LO;
    // bus commands on the command/enable lines
    localparam logic [3:0] CMD_MEM_RD = 4'h6;
    localparam logic [3:0] CMD_MEM_WR = 4'h7;
    localparam logic [3:0] CMD_CFG_RD = 4'hA;
    localparam logic [3:0] CMD_CFG_WR = 4'hB;
    localparam logic [3:0] BE_ALL     = 4'h0;
    // memory window claimed by the target, 4 KiB aligned
    localparam logic [19:0] MEM_BASE  = 20'h0_0010;
    localparam logic [2:0]  DEVSEL_TMO = 3'h5;
    localparam logic [31:0] CFG_RDATA = 32'h0000_0000;
    // master completion codes
    localparam logic [1:0] MST_OK     = 2'h0;
    localparam logic [1:0] MST_RETRY  = 2'h1;
    localparam logic [1:0] MST_ABORT  = 2'h2;
    typedef enum logic [1:0] {T_IDLE, T_DATA, T_TURN} pbi_tgt_st_t;
    typedef enum logic [2:0] {M_IDLE, M_REQ, M_ADDR, M_DATA, M_TURN} pbi_mst_st_t;
endpackage

/* logic/pbi_top.sv */
// Purpose: bus pin interface, target with write FIFO and single-word master
// Assumes: bus clock is sys_clk; pins already split into in/out/enable
// Notes:   lock is input only; interrupt follows user level
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
module pbi_fifo #(
    parameter int W  = 32,
    parameter int D  = 32,
    parameter int AW = 5
) (
    // clock and reset
    input  wire logic          sys_clk,
    input  wire logic          rst_b,
    // fill side
    input  wire logic          in_valid,
    output logic               in_ready,
    input  wire logic [W-1:0]  in_data,
    // drain side
    output logic               out_valid,
    input  wire logic          out_ready,
    output logic [W-1:0]       out_data,
    output logic [AW:0]        level
);
    logic [W-1:0]  mem_q [D];
    logic [AW-1:0] wp_q, wp_d, rp_q, rp_d;
    logic [AW:0]   cnt_q, cnt_d;
    logic          full_q, full_d, empty_q, empty_d;
    logic          push, pop;

    // flags kept as flops so both sides see registered handshakes
    always_comb begin
        push    = in_valid && !full_q;
        pop     = out_ready && !empty_q;
        wp_d    = push ? wp_q + 1'b1 : wp_q;
        rp_d    = pop ? rp_q + 1'b1 : rp_q;
        cnt_d   = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
        full_d  = (cnt_d == (AW+1)'(D));
        empty_d = (cnt_d == '0);
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            wp_q    <= '0;
            rp_q    <= '0;
            cnt_q   <= '0;
            full_q  <= 1'b0;
            empty_q <= 1'b1;
        end else begin
            wp_q    <= wp_d;
            rp_q    <= rp_d;
            cnt_q   <= cnt_d;
            full_q  <= full_d;
            empty_q <= empty_d;
        end
        if (push) begin
            mem_q[wp_q] <= in_data;
        end
    end

    assign in_ready  = !full_q;
    assign out_valid = !empty_q;
    assign out_data  = mem_q[rp_q];
    assign level     = cnt_q;
endmodule

////////////////////////////////////////////////////////////////////////////////
module pbi_top
    import pbi_pkg::*;
(
    // clock and reset
    input  wire logic                     sys_clk,
    input  wire logic                     rst_b,
    // address/data and command/enable lines
    input  wire logic [pbi_pkg::DATA_W-1:0] ad_i,
    output logic [pbi_pkg::DATA_W-1:0]    ad_o,
    output logic                          ad_oe,
    input  wire logic [pbi_pkg::CBE_W-1:0] cbe_b_i,
    output logic [pbi_pkg::CBE_W-1:0]     cbe_b_o,
    output logic                          cbe_oe,
    input  wire logic                     par_i,
    output logic                          par_o,
    output logic                          par_oe,
    // framing
    input  wire logic                     frame_b_i,
    output logic                          frame_b_o,
    output logic                          frame_oe,
    input  wire logic                     irdy_b_i,
    output logic                          irdy_b_o,
    output logic                          irdy_oe,
    input  wire logic                     trdy_b_i,
    output logic                          trdy_b_o,
    output logic                          trdy_oe,
    input  wire logic                     stop_b_i,
    output logic                          stop_b_o,
    output logic                          stop_oe,
    input  wire logic                     devsel_b_i,
    output logic                          devsel_b_o,
    output logic                          devsel_oe,
    input  wire logic                     lock_b_i,
    input  wire logic                     idsel_i,
    // arbitration
    output logic                          req_b,
    input  wire logic                     gnt_b_i,
    // errors and interrupt; open-drain pins drive low while enabled
    input  wire logic                     perr_b_i,
    output logic                          perr_b_o,
    output logic                          perr_oe,
    output logic                          serr_oe,
    output logic                          inta_oe,
    // user side: events and master write request
    input  wire logic                     int_req,
    input  wire logic                     fatal_err,
    input  wire logic                     m_valid,
    output logic                          m_ready,
    input  wire logic [pbi_pkg::DATA_W-1:0] m_addr,
    input  wire logic [pbi_pkg::DATA_W-1:0] m_data,
    output logic                          m_done,
    output logic [1:0]                    m_stat,
    // user side: target write data
    output logic                          rx_valid,
    input  wire logic                     rx_ready,
    output logic [pbi_pkg::DATA_W-1:0]    rx_data
);
    import pbi_pkg::*;

    pbi_tgt_st_t       t_st_q, t_st_d;
    pbi_mst_st_t       m_st_q, m_st_d;
    logic [DATA_W-1:0] ad_q, ad_d, ma_q, ma_d, md_q, md_d, rdata;
    logic [CBE_W-1:0]  cbe_q, cbe_d;
    logic              ad_oe_q, ad_oe_d, cbe_oe_q, cbe_oe_d;
    logic              frame_q, frame_d, frame_oe_q, frame_oe_d;
    logic              irdy_q, irdy_d, irdy_oe_q, irdy_oe_d;
    logic              trdy_q, trdy_d, trdy_oe_q, trdy_oe_d;
    logic              stop_q, stop_d, stop_oe_q, stop_oe_d;
    logic              dev_q, dev_d, dev_oe_q, dev_oe_d;
    logic              req_q, req_d, lock_q, lock_d, frm_prev_q;
    logic              t_rd_q, t_rd_d, t_cfg_q, t_cfg_d;
    logic              mrdy_q, mrdy_d, mdone_q, mdone_d;
    logic [1:0]        mstat_q, mstat_d;
    logic [2:0]        tmo_q, tmo_d;
    logic              start, cfg_hit, mem_hit, xfer, push, f_in_ready;
    logic [FIFO_AW:0]  f_lvl;

    ////////////////////////////////////////////////////////////////////////////
    // decode of the sampled pins, all on the current edge
    always_comb begin
        start   = !frame_b_i && frm_prev_q && irdy_b_i;                    // see R4
        cfg_hit = (cbe_b_i == CMD_CFG_RD || cbe_b_i == CMD_CFG_WR) && idsel_i; // see R12
        mem_hit = (cbe_b_i == CMD_MEM_RD || cbe_b_i == CMD_MEM_WR)
                  && (ad_i[DATA_W-1:DEC_LO] == MEM_BASE);
        xfer    = !irdy_b_i && !trdy_q && trdy_oe_q;                        // see R8
        push    = (t_st_q == T_DATA) && xfer && !t_rd_q && !t_cfg_q;
        rdata   = t_cfg_q ? CFG_RDATA
                          : DATA_W'({lock_q, (m_st_q != M_IDLE), f_lvl});
    end

    ////////////////////////////////////////////////////////////////////////////
    // target and master state; the two never drive the lines together
    always_comb begin
        t_st_d = t_st_q;  m_st_d = m_st_q;
        ad_d = ad_q;  ad_oe_d = ad_oe_q;  cbe_d = cbe_q;  cbe_oe_d = cbe_oe_q;
        frame_d = frame_q;  frame_oe_d = frame_oe_q;
        irdy_d = irdy_q;  irdy_oe_d = irdy_oe_q;
        trdy_d = trdy_q;  trdy_oe_d = trdy_oe_q;
        stop_d = stop_q;  stop_oe_d = stop_oe_q;
        dev_d = dev_q;  dev_oe_d = dev_oe_q;
        req_d = req_q;  lock_d = lock_q;  t_rd_d = t_rd_q;  t_cfg_d = t_cfg_q;
        ma_d = ma_q;  md_d = md_q;  tmo_d = tmo_q;  mstat_d = mstat_q;
        mrdy_d = 1'b0;
        mdone_d = 1'b0;
        // target side
        case (t_st_q)
            T_IDLE: begin
                if (frame_b_i && lock_b_i) begin
                    lock_d = 1'b0;
                end
                if (start && (cfg_hit || mem_hit) && m_st_q == M_IDLE) begin
                    t_st_d = T_DATA;
                    dev_d = 1'b0;                               // see R13
                    dev_oe_d = 1'b1;
                    trdy_d = 1'b1;
                    trdy_oe_d = 1'b1;
                    stop_oe_d = 1'b1;
                    // a held lock and a foreign locked access earn a retry
                    stop_d = !(lock_q && !lock_b_i);            // see R10
                    t_rd_d = !cbe_b_i[0];
                    t_cfg_d = cfg_hit;
                end
            end
            T_DATA: begin
                if (!stop_q) begin
                    if (frame_b_i) begin                        // see R9
                        t_st_d = T_TURN;
                    end
                end else if (xfer) begin
                    if (!lock_b_i) begin
                        lock_d = 1'b1;                          // see R10
                    end
                    if (frame_b_i) begin
                        t_st_d = T_TURN;
                    end else begin
                        trdy_d = !t_rd_q;  // writes pause a clock per word
                    end
                end else if (frame_b_i && irdy_b_i) begin
                    t_st_d = T_TURN;
                end else if (t_rd_q) begin
                    ad_d = rdata;
                    ad_oe_d = 1'b1;
                    trdy_d = 1'b0;                              // see R7
                end else begin
                    trdy_d = !f_in_ready;    // back-pressure from the FIFO
                end
                if (t_st_d == T_TURN) begin
                    dev_d = 1'b1;
                    trdy_d = 1'b1;
                    stop_d = 1'b1;
                    ad_oe_d = 1'b0;
                end
            end
            T_TURN: begin
                // lines were driven high for one clock, now released
                dev_oe_d = 1'b0;
                trdy_oe_d = 1'b0;
                stop_oe_d = 1'b0;
                t_st_d = T_IDLE;
            end
            default: t_st_d = T_IDLE;
        endcase
        // master side: single-word memory write, never touches lock
        case (m_st_q)                                           // see R11
            M_IDLE: begin
                if (m_valid) begin
                    ma_d = m_addr;
                    md_d = m_data;
                    mrdy_d = 1'b1;
                    req_d = 1'b0;                               // see R15
                    m_st_d = M_REQ;
                end
            end
            M_REQ: begin
                if (!gnt_b_i && frame_b_i && irdy_b_i && t_st_q == T_IDLE) begin
                    m_st_d = M_ADDR;                            // see R16
                    frame_d = 1'b0;                             // see R4
                    frame_oe_d = 1'b1;
                    ad_d = ma_q;
                    ad_oe_d = 1'b1;
                    cbe_d = CMD_MEM_WR;
                    cbe_oe_d = 1'b1;
                    req_d = 1'b1;
                end
            end
            M_ADDR: begin
                m_st_d = M_DATA;
                frame_d = 1'b1;                                 // see R5
                irdy_d = 1'b0;                                  // see R6
                irdy_oe_d = 1'b1;
                ad_d = md_q;
                cbe_d = BE_ALL;
                tmo_d = '0;
            end
            M_DATA: begin
                tmo_d = tmo_q + 3'h1;  // see R14
                if (!devsel_b_i && !trdy_b_i) begin             // see R14
                    mstat_d = MST_OK;
                    m_st_d = M_TURN;
                end else if (!stop_b_i) begin                   // see R9
                    mstat_d = MST_RETRY;
                    m_st_d = M_TURN;
                end else if (devsel_b_i && tmo_q == DEVSEL_TMO) begin
                    mstat_d = MST_ABORT;
                    m_st_d = M_TURN;
                end
                if (m_st_d == M_TURN) begin
                    irdy_d = 1'b1;
                    frame_oe_d = 1'b0;
                    ad_oe_d = 1'b0;
                    cbe_oe_d = 1'b0;
                    mdone_d = 1'b1;
                end
            end
            M_TURN: begin
                irdy_oe_d = 1'b0;
                m_st_d = M_IDLE;
            end
            default: m_st_d = M_IDLE;
        endcase
    end

    // everything below changes only on the rising edge
    always_ff @(posedge sys_clk) begin                          // see R1
        if (!rst_b) begin                                       // see R3
            t_st_q <= T_IDLE;  m_st_q <= M_IDLE;
            ad_q <= '0;  ad_oe_q <= 1'b0;  cbe_q <= '1;  cbe_oe_q <= 1'b0;
            frame_q <= 1'b1;  frame_oe_q <= 1'b0;  irdy_q <= 1'b1;  irdy_oe_q <= 1'b0;
            trdy_q <= 1'b1;  trdy_oe_q <= 1'b0;  stop_q <= 1'b1;  stop_oe_q <= 1'b0;
            dev_q <= 1'b1;  dev_oe_q <= 1'b0;  req_q <= 1'b1;  lock_q <= 1'b0;
            t_rd_q <= 1'b0;  t_cfg_q <= 1'b0;  ma_q <= '0;  md_q <= '0;
            tmo_q <= '0;  mstat_q <= MST_OK;  mrdy_q <= 1'b0;  mdone_q <= 1'b0;
            frm_prev_q <= 1'b1;
        end else begin
            t_st_q <= t_st_d;  m_st_q <= m_st_d;
            ad_q <= ad_d;  ad_oe_q <= ad_oe_d;  cbe_q <= cbe_d;  cbe_oe_q <= cbe_oe_d;
            frame_q <= frame_d;  frame_oe_q <= frame_oe_d;
            irdy_q <= irdy_d;  irdy_oe_q <= irdy_oe_d;
            trdy_q <= trdy_d;  trdy_oe_q <= trdy_oe_d;
            stop_q <= stop_d;  stop_oe_q <= stop_oe_d;
            dev_q <= dev_d;  dev_oe_q <= dev_oe_d;  req_q <= req_d;  lock_q <= lock_d;
            t_rd_q <= t_rd_d;  t_cfg_q <= t_cfg_d;  ma_q <= ma_d;  md_q <= md_d;
            tmo_q <= tmo_d;  mstat_q <= mstat_d;  mrdy_q <= mrdy_d;  mdone_q <= mdone_d;
            frm_prev_q <= frame_b_i;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // parity, error reporting and interrupt
    logic              par_q, par_d, par_oe_q, par_oe_d;
    logic              perr_q, perr_d, perr_oe_q, perr_oe_d;
    logic              serr_q, serr_d, inta_q, inta_d;
    logic              dchk_q, dchk_d, achk_q, achk_d, bad;
    logic [DATA_W-1:0] cw_q, cw_d;
    logic [CBE_W-1:0]  cb_q, cb_d;

    // received words are checked when their parity arrives a clock later
    always_comb begin
        par_d = ^{ad_q, cbe_q};                                 // see R22
        par_oe_d = ad_oe_q;
        cw_d = ad_i;
        cb_d = cbe_b_i;
        dchk_d = push || ((t_st_q == T_DATA) && xfer && t_cfg_q && !t_rd_q);
        achk_d = (t_st_q == T_IDLE) && start && (cfg_hit || mem_hit);
        bad = (^{cw_q, cb_q}) != par_i;
        perr_d = 1'b1;
        perr_oe_d = 1'b0;
        if (dchk_q && bad) begin
            perr_d = 1'b0;                                      // see R17
            perr_oe_d = 1'b1;
        end else if (perr_oe_q && !perr_q) begin
            perr_oe_d = 1'b1;                                   // see R18
        end
        serr_d = (achk_q && bad) || fatal_err;                  // see R19
        inta_d = int_req;                                       // see R20 R21
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            par_q <= 1'b0;  par_oe_q <= 1'b0;  perr_q <= 1'b1;  perr_oe_q <= 1'b0;
            serr_q <= 1'b0;  inta_q <= 1'b0;  dchk_q <= 1'b0;  achk_q <= 1'b0;
            cw_q <= '0;  cb_q <= '0;
        end else begin
            par_q <= par_d;  par_oe_q <= par_oe_d;  perr_q <= perr_d;
            perr_oe_q <= perr_oe_d;  serr_q <= serr_d;  inta_q <= inta_d;
            dchk_q <= dchk_d;  achk_q <= achk_d;  cw_q <= cw_d;  cb_q <= cb_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // write data buffer; a full FIFO holds target ready off
    pbi_fifo #(.W(DATA_W), .D(FIFO_DEPTH), .AW(FIFO_AW)) u_fifo (
        .sys_clk   (sys_clk),
        .rst_b     (rst_b),
        .in_valid  (push),
        .in_ready  (f_in_ready),
        .in_data   (ad_i),
        .out_valid (rx_valid),
        .out_ready (rx_ready),
        .out_data  (rx_data),
        .level     (f_lvl)
    );

    assign ad_o = ad_q;          assign ad_oe = ad_oe_q;
    assign cbe_b_o = cbe_q;      assign cbe_oe = cbe_oe_q;
    assign par_o = par_q;        assign par_oe = par_oe_q;
    assign frame_b_o = frame_q;  assign frame_oe = frame_oe_q;
    assign irdy_b_o = irdy_q;    assign irdy_oe = irdy_oe_q;
    assign trdy_b_o = trdy_q;    assign trdy_oe = trdy_oe_q;
    assign stop_b_o = stop_q;    assign stop_oe = stop_oe_q;
    assign devsel_b_o = dev_q;   assign devsel_oe = dev_oe_q;
    assign req_b = req_q;        assign perr_b_o = perr_q;
    assign perr_oe = perr_oe_q;  assign serr_oe = serr_q;
    assign inta_oe = inta_q;     assign m_ready = mrdy_q;
    assign m_done = mdone_q;     assign m_stat = mstat_q;

    ////////////////////////////////////////////////////////////////////////////
    // checks on driven lines
    a_reset_float: assert property (@(posedge sys_clk) // see R3
        $past(!rst_b) |-> !(ad_oe_q || frame_oe_q || trdy_oe_q || serr_q || perr_oe_q))
        else $error("outputs driven right after reset");
    a_start_granted: assert property (@(posedge sys_clk) disable iff (!rst_b) // see R16
        $rose(frame_oe_q) |-> !$past(gnt_b_i) && !$past(req_q))
        else $error("frame started without grant");
    a_addr_phase: assert property (@(posedge sys_clk) disable iff (!rst_b) // see R4
        $rose(frame_oe_q) |-> !frame_q && ad_oe_q && cbe_q == CMD_MEM_WR ##1 !irdy_q)
        else $error("address phase malformed");
    a_last_phase: assert property (@(posedge sys_clk) disable iff (!rst_b) // see R5
        (irdy_oe_q && !irdy_q) |-> frame_q && frame_oe_q && ad_oe_q)
        else $error("data phase without frame released");
    a_read_data: assert property (@(posedge sys_clk) disable iff (!rst_b) // see R7
        (trdy_oe_q && !trdy_q && t_rd_q) |-> ad_oe_q && ad_q == rdata)
        else $error("target ready without read data");
    a_lock_retry: assert property (@(posedge sys_clk) disable iff (!rst_b) // see R10
        (t_st_q == T_IDLE && start && mem_hit && lock_q && !lock_b_i && m_st_q == M_IDLE)
        |=> !stop_q && !dev_q ##1 trdy_q)
        else $error("locked target did not retry");
    a_cfg_select: assert property (@(posedge sys_clk) disable iff (!rst_b) // see R12
        ($fell(dev_q) && t_cfg_q) |-> $past(idsel_i))
        else $error("configuration claimed without select");
    a_abort_time: assert property (@(posedge sys_clk) disable iff (!rst_b) // see R14
        (m_st_q == M_ADDR) ##1 (devsel_b_i && trdy_b_i && stop_b_i) [*6] |=> mdone_q)
        else $error("master abort not taken");
    a_req_raise: assert property (@(posedge sys_clk) disable iff (!rst_b) // see R15
        (m_st_q == M_IDLE && m_valid) |=> !req_q && mrdy_q)
        else $error("request not raised");
    a_perr_delay: assert property (@(posedge sys_clk) disable iff (!rst_b) // see R17
        (dchk_d && (^{ad_i, cbe_b_i})) ##1 !par_i |=> !perr_q && perr_oe_q)
        else $error("parity error not reported two clocks on");
    a_perr_release: assert property (@(posedge sys_clk) disable iff (!rst_b) // see R18
        (perr_oe_q && !perr_q) ##1 !(dchk_q && bad) |-> perr_q && perr_oe_q ##1 !perr_oe_q)
        else $error("parity error line not released high");
    a_par_cover: assert property (@(posedge sys_clk) disable iff (!rst_b) // see R22
        $past(ad_oe_q) |-> par_oe_q && par_q == ^{$past(ad_q), $past(cbe_q)})
        else $error("parity output wrong");
    a_serr_fatal: assert property (@(posedge sys_clk) disable iff (!rst_b) // see R19
        fatal_err |=> serr_q)
        else $error("system error not raised");
    a_int_level: assert property (@(posedge sys_clk) disable iff (!rst_b) // see R20
        int_req [*2] |-> inta_q ##1 inta_q)
        else $error("interrupt not held");
endmodule

`default_nettype wire

/* test/pbi_far_model.sv */
// Purpose: arbiter and target facing the design's master side
// Assumes: pin levels are resolved, high when released
// Notes:   mode 0 fast, 1 stop, 2 no claim, 3 slow ready
`timescale 1ns/1ps
`default_nettype none
module pbi_far_model (
    // clock and bus levels
    input  wire logic       sys_clk,
    input  wire logic       req_b,
    input  wire logic       frame_b,
    input  wire logic       irdy_b,
    input  wire logic [1:0] mode,
    // driven levels
    output logic            gnt_b,
    output logic            devsel_b,
    output logic            trdy_b,
    output logic            stop_b
);
    logic frame_q;
    initial {gnt_b, devsel_b, trdy_b, stop_b, frame_q} = 5'h1f;
    // claims only while it grants, so bench writes stay unclaimed here
    always @(posedge sys_clk) begin
        gnt_b   <= req_b;
        frame_q <= frame_b;
        if (frame_q && !frame_b && !gnt_b && mode != 2'h2) begin
            devsel_b <= 1'b0;
            trdy_b   <= mode != 2'h0;
            stop_b   <= mode != 2'h1;
        end else if (!irdy_b && !devsel_b && !(trdy_b && stop_b)) begin
            {devsel_b, trdy_b, stop_b} <= 3'h7;
        end else if (!devsel_b && stop_b) begin
            trdy_b <= 1'b0;
        end
    end
endmodule
`default_nettype wire

/* test/pbi_top_tb_top.sv */
// Purpose: self-checking bench for the bus pin interface
// Assumes: pull-ups on control lines, bench drives ad while released
// Notes:   scoreboard queues hold fifo words and master codes
`timescale 1ns/1ps
`default_nettype none
module pbi_top_tb_top;
    import pbi_pkg::*;
    logic        sys_clk, rst_b, tb_frame, tb_irdy, tb_par, bad, int_req, fatal_err;
    logic        m_valid, rx_ready, drain, md, mt, ms, lock_b_i, idsel_i, perr_b_i;
    logic        ad_oe, cbe_oe, par_o, par_oe, frame_b_o, frame_oe, irdy_b_o, irdy_oe;
    logic        trdy_b_o, trdy_oe, stop_b_o, stop_oe, devsel_b_o, devsel_oe, req_b;
    logic        perr_b_o, perr_oe, serr_oe, inta_oe, m_ready, m_done, rx_valid, gnt_b_i;
    logic        par_i, frame_b_i, irdy_b_i, trdy_b_i, stop_b_i, devsel_b_i;
    logic [31:0] tb_ad, m_addr, m_data, rnd, ad_o, ad_i, rx_data, q_rx[$];
    logic [3:0]  tb_cbe, cbe_b_o, cbe_b_i;
    logic [1:0]  mode, m_stat, q_st[$];
    int          failures, n_checks, k;
    // wired levels: whoever enables drives, else the other side
    assign {ad_i, cbe_b_i} = ad_oe ? {ad_o, cbe_b_o} : {tb_ad, tb_cbe};
    assign par_i = par_oe ? par_o : tb_par;
    assign frame_b_i = frame_oe ? frame_b_o : tb_frame;
    assign irdy_b_i = irdy_oe ? irdy_b_o : tb_irdy;
    assign {trdy_b_i, stop_b_i} = {trdy_oe ? trdy_b_o : mt, stop_oe ? stop_b_o : ms};
    assign devsel_b_i = devsel_oe ? devsel_b_o : md;
    assign {lock_b_i, idsel_i, perr_b_i} = 3'h5;
    pbi_top u_dut (.*);
    pbi_far_model u_far (.sys_clk, .req_b, .frame_b(frame_b_i), .irdy_b(irdy_b_i), .mode,
        .gnt_b(gnt_b_i), .devsel_b(md), .trdy_b(mt), .stop_b(ms));
    function automatic logic [31:0] xs(logic [31:0] x);
        x ^= x << 13;
        x ^= x >> 17;
        return x ^ (x << 5);
    endfunction
    task automatic cyc(int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    task automatic chk(logic ok, string s);
        n_checks++;
        if (!ok) begin
            failures++;
            $display("[ERR] %0t %s", $time, s);
        end
    endtask
    task automatic complete_run;
        if (failures == 0 && n_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic tmo(int n);
        if (n >= 50) begin
            chk(1'b0, "wait ran out");
            complete_run();
        end
    endtask
    // bench as master: n-word memory write burst
    task automatic twr(int n, logic [31:0] a);
        cyc(3);
        {tb_frame, tb_ad, tb_cbe} = {1'b0, a, CMD_MEM_WR};
        for (int i = 0; i < n; i++) begin
            cyc(1);
            {tb_frame, tb_irdy, tb_ad, tb_cbe} = {i == n - 1, 1'b0, rnd, BE_ALL};
            q_rx.push_back(tb_ad);
            for (k = 0; k < 50; k++) begin
                @(negedge sys_clk);
                if (k == 20) drain = 1'b1; // full fifo holds the word
                if (trdy_b_i === 1'b0) break;
            end
            tmo(k);
            chk(devsel_b_i === 1'b0 && (i != 32 || k >= 20), "claim or refusal");
        end
        cyc(1);
        {tb_frame, tb_irdy, tb_ad} = {2'h3, ~tb_ad};
        cyc(1);
    endtask
    // parity one clock behind; bad flips it on purpose
    always @(posedge sys_clk) tb_par <= ^{ad_i, cbe_b_i} ^ bad;
    // ready stalls at random so the drain side sees backpressure
    always @(posedge sys_clk) begin
        #1;
        rnd = xs(rnd);
        rx_ready = drain & (rnd[0] | rnd[1]);
    end
    // result watcher: oldest note against each delivered result
    always @(negedge sys_clk) begin
        if (rx_valid === 1'b1 && rx_ready === 1'b1) begin
            chk(q_rx.size() > 0 && rx_data === q_rx.pop_front(), "fifo word");
        end
        if (m_done === 1'b1) chk(q_st.size() > 0 && m_stat === q_st.pop_front(), "code");
    end
    initial begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end
    initial begin
        {rst_b, bad, int_req, fatal_err, m_valid, drain, rx_ready, tb_par} = 8'h00;
        {tb_frame, tb_irdy, tb_ad, tb_cbe, m_addr, m_data, mode} = 0;
        {tb_frame, tb_irdy, rnd, failures, n_checks} = {2'h3, 32'h0000_0054, 64'h0};
        cyc(10);
        chk({ad_oe, frame_oe, trdy_oe, devsel_oe, perr_oe, serr_oe, req_b} === 7'h01, "rst");
        rst_b = 1'b1;
        twr(33, {MEM_BASE, 12'h000});
        bad = 1'b1;
        twr(1, {MEM_BASE, 12'h010});
        bad = 1'b0;
        for (k = 0; k < 50 && !(perr_oe === 1'b1 && perr_b_o === 1'b0); k++) cyc(1);
        chk(k < 3, "parity report");
        for (int j = 0; j < 4; j++) begin
            {mode, m_valid, m_addr, m_data} = {j[1:0], 1'b1, rnd, ~rnd};
            q_st.push_back(j == 1 ? MST_RETRY : j == 2 ? MST_ABORT : MST_OK);
            for (k = 0; k < 50 && m_ready !== 1'b1; k++) cyc(1);
            tmo(k);
            m_valid = 1'b0;
            chk(req_b === 1'b0, "request");
            for (k = 0; k < 50 && !(frame_oe === 1'b1 && frame_b_o === 1'b0); k++) cyc(1);
            chk({ad_o, cbe_b_o, gnt_b_i} === {m_addr, CMD_MEM_WR, 1'h0}, "addr");
            for (k = 0; k < 50 && m_done !== 1'b1; k++) cyc(1);
            tmo(k);
            cyc(4);
        end
        {int_req, fatal_err} = 2'h3;
        cyc(2);
        chk(inta_oe === 1'b1 && serr_oe === 1'b1, "events on");
        {int_req, fatal_err} = 2'h0;
        cyc(2);
        chk(inta_oe === 1'b0 && serr_oe === 1'b0 && q_rx.size() == 0, "events off");
        complete_run();
    end
endmodule
`default_nettype wire
